// File: dpami_consts.svh
`ifndef DPAMI_CONSTS_SVH
`define DPAMI_CONSTS_SVH
// Register indices; byte address is four times the index
`define DPAMI_IDX_ACCESS 16'h0101
`define DPAMI_IDX_MODE 16'h0102
`define DPAMI_IDX_STATUS 16'h0180
`define DPAMI_IDX_PARAM_BASE 16'h0100
`define DPAMI_RST_ACCESS 16'h0001
`define DPAMI_RST_MODE 16'h0000
// Parameter number limits per access level
`define DPAMI_LIM_L1 8'h31
`define DPAMI_LIM_L2 8'h4F
`define DPAMI_LIM_L3 8'h77
`define DPAMI_LIM_L4 8'hB3
// Selector command values
`define DPAMI_CMD_CLR_LOG 16'h0006
`define DPAMI_CMD_INIT_2W 16'h0008
`define DPAMI_CMD_INIT_3W 16'h0009
`define DPAMI_CMD_USA_2W 16'h000A
`define DPAMI_CMD_USA_3W 16'h000B
// Defaults, 0.1 unit steps (frequency Hz, voltage V, time s, gain)
`define DPAMI_MID_F_VF 16'h000F
`define DPAMI_MID_F_VEC 16'h001E
`define DPAMI_MIN_F_VF 16'h000F
`define DPAMI_MIN_F_VEC 16'h000A
`define DPAMI_MID_V_VF 16'h0078
`define DPAMI_MID_V_VEC 16'h006E
`define DPAMI_MIN_V_VF 16'h0078
`define DPAMI_MIN_V_VEC 16'h002B
`define DPAMI_V_VF_BIG 16'h0064
`define DPAMI_TC_VF 16'h0003
`define DPAMI_TC_VEC 16'h0002
`define DPAMI_SD_VF 16'h0014
`define DPAMI_SD_VEC 16'h0002
`define DPAMI_SG_VF 16'h0000
`define DPAMI_SG_VEC 16'h000A
`endif

// File: dpami_pkg.sv
package dpami_pkg;
  typedef enum logic [0:0] {DPAMI_VF = 1'b0, DPAMI_VEC = 1'b1} dpami_mode_t;
  // Dependent tuning values produced by a reload
  typedef struct packed {
    logic [15:0] mid_freq;
    logic [15:0] mid_volt;
    logic [15:0] min_freq;
    logic [15:0] min_volt;
    logic [15:0] torque_delay;
    logic [15:0] slip_gain;
    logic [15:0] slip_delay;
  } dpami_tune_t;
endpackage

// File: dpami_defaults.sv
`timescale 1ns/1ps
`include "dpami_consts.svh"
module dpami_defaults
(
  // Selection
  input wire dpami_pkg::dpami_mode_t mode,
  input wire logic class_400v,
  input wire logic big_rating,
  // Result
  output dpami_pkg::dpami_tune_t tune
);
  logic [15:0] vf_volt;

  // Large ratings use a lower V/f voltage
  assign vf_volt = big_rating ? `DPAMI_V_VF_BIG : `DPAMI_MID_V_VF;

  // Per-mode default table, voltages doubled for 400-volt class
  always_comb
  begin
    if (mode == dpami_pkg::DPAMI_VEC)
    begin
      tune.mid_freq = `DPAMI_MID_F_VEC;
      tune.min_freq = `DPAMI_MIN_F_VEC;
      tune.mid_volt = `DPAMI_MID_V_VEC;
      tune.min_volt = `DPAMI_MIN_V_VEC;
      tune.torque_delay = `DPAMI_TC_VEC;
      tune.slip_gain = `DPAMI_SG_VEC;
      tune.slip_delay = `DPAMI_SD_VEC;
    end
    else
    begin
      tune.mid_freq = `DPAMI_MID_F_VF;
      tune.min_freq = `DPAMI_MIN_F_VF;
      tune.mid_volt = big_rating ? vf_volt : `DPAMI_MID_V_VF;
      tune.min_volt = big_rating ? vf_volt : `DPAMI_MIN_V_VF;
      tune.torque_delay = `DPAMI_TC_VF;
      tune.slip_gain = `DPAMI_SG_VF;
      tune.slip_delay = `DPAMI_SD_VF;
    end
    if (class_400v)
    begin
      tune.mid_volt = {tune.mid_volt[14:0], 1'b0};
      tune.min_volt = {tune.min_volt[14:0], 1'b0};
    end
  end
endmodule

// File: dpami_top.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "dpami_consts.svh"
module dpami_top
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive status and straps
  input wire logic drive_running,
  input wire logic class_400v,
  input wire logic big_rating,
  // Outputs to the parameter store
  output logic fault_log_clear,
  output logic reload_pulse,
  output logic reload_three_wire,
  output logic reload_usa,
  output dpami_pkg::dpami_tune_t tune,
  output dpami_pkg::dpami_mode_t control_mode,
  output logic [7:0] write_limit,
  output logic [7:0] show_limit
);
  logic [15:0] access_level;
  dpami_pkg::dpami_mode_t mode_q;
  dpami_pkg::dpami_tune_t next_tune;
  logic [15:0] param_store [0:6];
  logic [7:0] reload_count;
  logic [7:0] reject_count;
  logic [15:0] idx;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic [7:0] pnum;
  logic param_hit;
  logic [31:0] next_rdata;

  // Highest parameter number a level opens
  function automatic logic [7:0] level_limit(input logic [15:0] lvl);
    case (lvl)
      16'h0001: level_limit = `DPAMI_LIM_L1;
      16'h0002: level_limit = `DPAMI_LIM_L2;
      16'h0003: level_limit = `DPAMI_LIM_L3;
      16'h0004: level_limit = `DPAMI_LIM_L4;
      default: level_limit = 8'h01;
    endcase
  endfunction

  // Values the selector may be written with
  function automatic logic legal_level(input logic [31:0] v);
    legal_level = (v[31:4] == 28'h0000000) && (v[3:0] <= 4'hB)
      && (v[3:0] != 4'h5) && (v[3:0] != 4'h7);
  endfunction

  dpami_defaults u_defaults
  (
    .mode(mode_q),
    .class_400v(class_400v),
    .big_rating(big_rating),
    .tune(next_tune)
  );

  // Decode; word index taken from the byte address
  assign idx = {6'h00, paddr[11:2]};
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready;
  assign pnum = idx[7:0];
  assign param_hit = (idx[15:8] == `DPAMI_IDX_PARAM_BASE >> 8) && (pnum >= 8'h01)
    && (pnum <= 8'hB3);
  assign mapped = param_hit || idx == `DPAMI_IDX_STATUS;

  // No wait states: pready rises in the first access cycle, read data registered in setup
  // Limitation: a setup cycle that falls while clk_en is low is lost, so the
  // master must keep clk_en high for the whole of a transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (clk_en)
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (clk_en)
      pslverr <= setup && !mapped;
  end

  // Read mux; level 0 still shows everything, levels 1-4 hide above limit
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (idx == `DPAMI_IDX_STATUS)
      next_rdata = {16'h0000, reload_count, reject_count};
    else if (idx == `DPAMI_IDX_ACCESS)
      next_rdata = {16'h0000, access_level};
    else if (idx == `DPAMI_IDX_MODE)
      next_rdata = {31'h00000000, mode_q};
    else if (param_hit && pnum <= show_limit)
    begin
      case (pnum)
        8'h0E: next_rdata = {16'h0000, param_store[0]};
        8'h0F: next_rdata = {16'h0000, param_store[1]};
        8'h10: next_rdata = {16'h0000, param_store[2]};
        8'h11: next_rdata = {16'h0000, param_store[3]};
        8'h68: next_rdata = {16'h0000, param_store[4]};
        8'h6F: next_rdata = {16'h0000, param_store[5]};
        8'h70: next_rdata = {16'h0000, param_store[6]};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (clk_en && setup && !pwrite)
      prdata <= next_rdata;
  end

  // Selector: stores levels, commands act once and leave level unchanged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      access_level <= `DPAMI_RST_ACCESS;
    else if (clk_en && wr_acc && idx == `DPAMI_IDX_ACCESS && !drive_running
      && legal_level(pwdata) && pwdata[3:0] <= 4'h4)
      access_level <= pwdata[15:0];
  end

  // Mode selector; writable only at level 1 and up, 0/1 only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= dpami_pkg::DPAMI_VF;
    else if (clk_en && wr_acc && idx == `DPAMI_IDX_MODE && !drive_running
      && access_level != 16'h0000 && pwdata[31:1] == 31'h00000000)
      mode_q <= dpami_pkg::dpami_mode_t'(pwdata[0]);
  end

  // Command pulses out of selector writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_log_clear <= 1'b0;
      reload_pulse <= 1'b0;
      reload_three_wire <= 1'b0;
      reload_usa <= 1'b0;
    end
    else if (clk_en)
    begin
      fault_log_clear <= 1'b0;
      reload_pulse <= 1'b0;
      if (wr_acc && idx == `DPAMI_IDX_ACCESS && !drive_running && legal_level(pwdata))
      begin
        fault_log_clear <= pwdata[15:0] == `DPAMI_CMD_CLR_LOG;
        if (pwdata[3:0] >= 4'h8)
        begin
          reload_pulse <= 1'b1;
          reload_three_wire <= pwdata[0];
          reload_usa <= pwdata[3:0] >= `DPAMI_CMD_USA_2W;
        end
      end
    end
  end

  // Reload copies current-mode defaults; mode register untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tune <= '0;
      for (int i = 0; i < 7; i++)
        param_store[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (reload_pulse)
      begin
        tune <= next_tune;
        param_store[0] <= next_tune.mid_freq;
        param_store[1] <= next_tune.mid_volt;
        param_store[2] <= next_tune.min_freq;
        param_store[3] <= next_tune.min_volt;
        param_store[4] <= next_tune.torque_delay;
        param_store[5] <= next_tune.slip_gain;
        param_store[6] <= next_tune.slip_delay;
      end
      else if (wr_acc && param_hit && pnum != 8'h02 && pnum <= write_limit)
      begin
        case (pnum)
          8'h0E: param_store[0] <= pwdata[15:0];
          8'h0F: param_store[1] <= pwdata[15:0];
          8'h10: param_store[2] <= pwdata[15:0];
          8'h11: param_store[3] <= pwdata[15:0];
          8'h68: param_store[4] <= pwdata[15:0];
          8'h6F: param_store[5] <= pwdata[15:0];
          8'h70: param_store[6] <= pwdata[15:0];
          default: param_store[0] <= param_store[0];
        endcase
      end
    end
  end

  // Visible state and counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_mode <= dpami_pkg::DPAMI_VF;
      write_limit <= 8'h01;
      show_limit <= `DPAMI_LIM_L1;
      reload_count <= 8'h00;
      reject_count <= 8'h00;
    end
    else if (clk_en)
    begin
      control_mode <= mode_q;
      write_limit <= level_limit(access_level);
      show_limit <= (access_level == 16'h0000) ? `DPAMI_LIM_L4 : level_limit(access_level);
      if (reload_pulse)
        reload_count <= reload_count + 8'h01;
      if (wr_acc && idx == `DPAMI_IDX_ACCESS && !legal_level(pwdata))
        reject_count <= reject_count + 8'h01;
    end
  end

  // Selector guards: refused values, commands and a running drive keep the level
  a_reject_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_acc && idx == `DPAMI_IDX_ACCESS && !legal_level(pwdata)
    |=> access_level == $past(access_level)) else $error("rejected level stored");
  a_cmd_keeps_level: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_acc && idx == `DPAMI_IDX_ACCESS && pwdata[3:0] >= 4'h6
    |=> access_level == $past(access_level)) else $error("command stored as level");
  a_run_locks_level: assert property (@(posedge pclk) disable iff (!presetn)
    drive_running && clk_en |=> access_level == $past(access_level))
    else $error("level changed running");
  a_run_locks_mode: assert property (@(posedge pclk) disable iff (!presetn)
    drive_running && clk_en |=> mode_q == $past(mode_q))
    else $error("mode changed running");
  a_zero_locks_mode: assert property (@(posedge pclk) disable iff (!presetn)
    access_level == 16'h0000 && clk_en |=> mode_q == $past(mode_q))
    else $error("mode changed at level zero");

  // Limits follow the stored level one cycle later
  a_level_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access_level == 16'h0000 && clk_en |=> write_limit == 8'h01)
    else $error("lock open");
  a_level_one: assert property (@(posedge pclk) disable iff (!presetn)
    access_level == 16'h0001 && clk_en |=> show_limit == 8'h31)
    else $error("level one range");
  a_level_four: assert property (@(posedge pclk) disable iff (!presetn)
    access_level == 16'h0004 && clk_en |=> write_limit == 8'hB3)
    else $error("limit bad");

  // Reload commands: pulse, wiring flags, untouched mode, current-mode defaults
  a_reload_wiring: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_acc && idx == `DPAMI_IDX_ACCESS && !drive_running
    && pwdata == 32'h00000009 |=> reload_pulse && reload_three_wire && !reload_usa)
    else $error("three-wire reload");
  a_reload_usa: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_acc && idx == `DPAMI_IDX_ACCESS && !drive_running
    && pwdata == 32'h0000000A |=> reload_pulse && reload_usa && !reload_three_wire)
    else $error("regional reload");
  a_reload_keeps_mode: assert property (@(posedge pclk) disable iff (!presetn)
    reload_pulse && clk_en |=> mode_q == $past(mode_q))
    else $error("reload changed mode");
  a_reload_matches: assert property (@(posedge pclk) disable iff (!presetn)
    reload_pulse && clk_en |=> tune == $past(next_tune))
    else $error("tune mismatch");
  a_vec_freq: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == dpami_pkg::DPAMI_VEC |-> next_tune.mid_freq == 16'h001E)
    else $error("vec freq");
  a_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    fault_log_clear && clk_en |=> !fault_log_clear)
    else $error("clear stuck");

  // Bus handshake and freeze; a frozen cycle must not move any state
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready && clk_en |=> !pready) else $error("pready held");
  a_freeze_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> access_level == $past(access_level) && mode_q == $past(mode_q)
    && pready == $past(pready)) else $error("state moved while frozen");

  c_reload: cover property (@(posedge pclk) reload_pulse);
  c_clear: cover property (@(posedge pclk) fault_log_clear);
  c_reject: cover property (@(posedge pclk) wr_acc && !legal_level(pwdata));
  c_vec_reload: cover property (@(posedge pclk)
    reload_pulse && mode_q == dpami_pkg::DPAMI_VEC);
  c_frozen_clear: cover property (@(posedge pclk) !clk_en && fault_log_clear);
endmodule

// File: dpami_top_tb.sv
`timescale 1ns/1ps
`include "dpami_consts.svh"
module dpami_top_tb;
  // Bench state and design inputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic drive_running = 1'b0;
  logic class_400v = 1'b0;
  logic big_rating = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_log_clear;
  logic reload_pulse;
  logic reload_three_wire;
  logic reload_usa;
  dpami_pkg::dpami_tune_t tune;
  dpami_pkg::dpami_mode_t control_mode;
  logic [7:0] write_limit;
  logic [7:0] show_limit;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [11:0] A_SEL = 12'h404;
  localparam logic [11:0] A_MODE = 12'h408;
  localparam logic [11:0] A_P17 = 12'h444;
  localparam logic [11:0] A_STAT = 12'h600;

  // Clock enable is driven so that a freeze can be exercised between transfers
  dpami_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_running(drive_running),
    .class_400v(class_400v), .big_rating(big_rating), .fault_log_clear(fault_log_clear),
    .reload_pulse(reload_pulse), .reload_three_wire(reload_three_wire),
    .reload_usa(reload_usa), .tune(tune), .control_mode(control_mode),
    .write_limit(write_limit), .show_limit(show_limit));

  always #25 pclk = ~pclk;

  // Cut a hang short; the whole run needs well under 2000 cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [111:0] seen, input logic [111:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
      chk("pready", 1'b0, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [15:0] exp, input string what);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 16'h0000, rd, er);
    chk(what, rd, {16'h0000, exp});
  endtask

  // Defaults per mode; big rating affects only V/f, high class doubles volts
  function automatic dpami_pkg::dpami_tune_t exp_tune(input logic m, input logic h,
    input logic b);
    dpami_pkg::dpami_tune_t t;
    logic [15:0] vf;
    vf = b ? `DPAMI_V_VF_BIG : `DPAMI_MID_V_VF;
    t.mid_freq = m ? `DPAMI_MID_F_VEC : `DPAMI_MID_F_VF;
    t.min_freq = m ? `DPAMI_MIN_F_VEC : `DPAMI_MIN_F_VF;
    t.mid_volt = (m ? `DPAMI_MID_V_VEC : vf) << h;
    t.min_volt = (m ? `DPAMI_MIN_V_VEC : vf) << h;
    t.torque_delay = m ? `DPAMI_TC_VEC : `DPAMI_TC_VF;
    t.slip_gain = m ? `DPAMI_SG_VEC : `DPAMI_SG_VF;
    t.slip_delay = m ? `DPAMI_SD_VEC : `DPAMI_SD_VF;
    return t;
  endfunction

  // Levels open their ranges; level 0 locks parameter and mode writes
  task automatic t_levels();
    logic [7:0] lim [5];
    lim = '{`DPAMI_LIM_L4, `DPAMI_LIM_L1, `DPAMI_LIM_L2, `DPAMI_LIM_L3, `DPAMI_LIM_L4};
    for (int lv = 4; lv >= 0; lv--)
    begin
      wr(A_SEL, lv[15:0]);
      repeat (2) @(negedge pclk);
      chk("show_limit", show_limit, lim[lv]);
      if (lv > 0)
        chk("write_limit", write_limit, lim[lv]);
      if (lv == 1)
      begin
        wr(A_P17, 16'h0055);
        rdc(A_P17, 16'h0055, "param17");
      end
    end
    wr(A_P17, 16'h0066);
    rdc(A_P17, 16'h0055, "param17 locked");
    wr(A_MODE, 16'h0001);
    rdc(A_MODE, 16'h0000, "mode locked");
  endtask

  // Clear, refused values, running lock
  task automatic t_commands();
    logic [15:0] bad [3];
    bad = '{16'h0005, 16'h0007, 16'h000C};
    wr(A_SEL, 16'h0002);
    wr(A_SEL, `DPAMI_CMD_CLR_LOG);
    @(negedge pclk);
    chk("fault_log_clear", fault_log_clear, 1'b1);
    rdc(A_SEL, 16'h0002, "sel after clear");
    foreach (bad[i])
    begin
      wr(A_SEL, bad[i]);
      rdc(A_SEL, 16'h0002, "sel refused");
    end
    wr(A_MODE, 16'h0002);
    rdc(A_MODE, 16'h0000, "mode refused");
    @(posedge pclk);
    drive_running <= 1'b1;
    wr(A_SEL, 16'h0003);
    wr(A_MODE, 16'h0001);
    rdc(A_SEL, 16'h0002, "sel running");
    rdc(A_MODE, 16'h0000, "mode running");
    @(posedge pclk);
    drive_running <= 1'b0;
    rdc(A_STAT, 16'h0003, "refusals counted");
  endtask

  // Clock enable low freezes a pending clear pulse and the limits
  task automatic t_freeze();
    wr(A_SEL, `DPAMI_CMD_CLR_LOG);
    clk_en <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("clear frozen", fault_log_clear, 1'b1);
    chk("level frozen", show_limit, `DPAMI_LIM_L2);
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("clear released", fault_log_clear, 1'b0);
  endtask

  // Every reload command in both modes, straps varied
  task automatic t_reload();
    dpami_pkg::dpami_tune_t t;
    for (int m = 0; m < 2; m++)
    begin
      wr(A_MODE, m[15:0]); // Mode chosen before any reload
      repeat (2) @(negedge pclk);
      chk("control_mode", control_mode, m[0]);
      for (int k = 0; k < 4; k++)
      begin
        @(posedge pclk);
        class_400v <= k[0];
        big_rating <= k[1];
        wr(A_SEL, `DPAMI_CMD_INIT_2W + k[15:0]);
        @(negedge pclk);
        chk("reload_pulse", reload_pulse, 1'b1);
        chk("three_wire", reload_three_wire, k[0]);
        chk("usa", reload_usa, k[1]);
        @(negedge pclk);
        t = exp_tune(m[0], k[0], k[1]);
        chk("tune", tune, t);
        rdc(A_P17, t.min_volt, "stored min volt");
        rdc(A_MODE, m[15:0], "mode kept");
      end
    end
  endtask

  initial
  begin
    logic [31:0] rd;
    logic er;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_SEL, `DPAMI_RST_ACCESS, "sel reset");
    rdc(A_MODE, `DPAMI_RST_MODE, "mode reset");
    chk("show_limit reset", show_limit, `DPAMI_LIM_L1);
    t_levels();
    t_commands();
    t_freeze();
    t_reload();
    rdc(A_STAT, 16'h0803, "reloads counted");
    apb(1'b0, 12'hFFC, 16'h0000, rd, er);
    chk("pslverr", er, 1'b1);
    end_of_test();
  end
endmodule
